/* nhc_host.sv */
// Overview of operation
// - At most four partial programs per page; the host counts 10h confirms on all pages and clears the count only on reset
// - End cached reads with final-read command
// - Never drive bus while device outputs
// - Data columns never beyond 4351
// - Single plane cache ends 80h then 10h
// - Cache-confirm end: poll status, then reset
// - Multi page cache ends 81h then 10h
// - Multi-page cache-confirm end: poll, then reset
module nhc_host #(
   parameter int RST_WAIT = nhc_pkg::RST_CYC
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rstn_i,
   // Request port
   input wire logic req_valid_i,
   input wire nhc_pkg::nhc_req_type req_i,
   output logic req_ready_o,
   output logic rdata_valid_o,
   output logic [7:0] rdata_o,
   output logic refused_o,
   output logic need_reset_o,
   // Flash pins
   output nhc_pkg::nhc_pins_type pins_o,
   input wire logic ready_busy_n_i,
   input wire logic [7:0] io_i,
   output logic [7:0] io_o,
   output logic io_oe_o
);
   import nhc_pkg::*;

   // The wait counter is 20 bits wide, so longer recoveries cannot be served
   if (RST_WAIT < 1 || RST_WAIT > 32'h000fffff) begin : g_bad_wait
      $error("RST_WAIT must fit the 20-bit wait counter");
   end

   typedef enum {ST_IDLE, ST_WLOW, ST_WHIGH, ST_RLOW, ST_RHIGH,
      ST_WB} nhc_state_type;

   nhc_state_type state_r;
   nhc_pins_type pins_r;
   logic [7:0] io_r;
   logic oe_r;
   logic [7:0] rdata_r;
   logic rvalid_r;
   logic refused_r;
   logic [19:0] cnt_r;
   logic [2:0] partial_r;
   logic reset_due_r;
   logic status_mode_r;
   logic last_cache_r;
   logic rb_sync;

   nhc_sync u_sync (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .async_i(ready_busy_n_i),
      .sync_o(rb_sync)
   );

   // Request classification
   wire is_cmd = req_i.op == NHC_OP_CMD;
   wire is_status = is_cmd && req_i.data == CMD_STATUS;
   wire is_reset = is_cmd && req_i.data == CMD_RESET;
   wire is_prog = is_cmd && req_i.data == CMD_PROG;
   wire is_cache = is_cmd && req_i.data == CMD_PROG_CACHE;
   wire is_data_in = is_cmd && (req_i.data == CMD_SERIAL_IN ||
      req_i.data == CMD_PLANE2_IN);
   wire is_rd_status = req_i.op == NHC_OP_RDATA && status_mode_r;
   wire bypass_busy = is_status || is_reset || is_rd_status;
   wire col_bad = req_i.op == NHC_OP_WDATA && req_i.col > COL_LAST;
   wire busy_block = !rb_sync && !bypass_busy;
   wire reset_block = reset_due_r && !is_reset && !is_status &&
      !is_rd_status;
   wire part_block = is_prog && partial_r >= 3'(PARTIAL_MAX);
   wire refuse = col_bad || busy_block || reset_block || part_block;
   wire idle = state_r == ST_IDLE;
   wire accept = idle && req_valid_i && !refuse;
   wire rd_req = req_i.op == NHC_OP_RDATA;

   assign req_ready_o = idle;
   assign pins_o = pins_r;
   assign io_o = io_r;
   assign io_oe_o = oe_r;
   assign rdata_o = rdata_r;
   assign rdata_valid_o = rvalid_r;
   assign refused_o = refused_r;
   assign need_reset_o = reset_due_r;

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         state_r <= ST_IDLE;
         pins_r <= '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1,
            read_strobe_n: 1'b1};
         io_r <= 8'h00;
         oe_r <= 1'b0;
         rdata_r <= 8'h00;
         rvalid_r <= 1'b0;
         refused_r <= 1'b0;
         cnt_r <= '0;
         partial_r <= '0;
         reset_due_r <= 1'b0;
         status_mode_r <= 1'b0;
         last_cache_r <= 1'b0;
      end else begin
         rvalid_r <= 1'b0;
         refused_r <= idle && req_valid_i && refuse;
         case (state_r)
            ST_IDLE: begin
               if (accept) begin
                  pins_r.ce_n <= 1'b0;
                  pins_r.cle <= is_cmd;
                  pins_r.ale <= req_i.op == NHC_OP_ADDR;
                  if (rd_req) begin
                     oe_r <= 1'b0;
                     pins_r.read_strobe_n <= 1'b0;
                     cnt_r <= 20'(REA_CYC);
                     state_r <= ST_RLOW;
                  end else begin
                     io_r <= req_i.data;
                     oe_r <= 1'b1;
                     pins_r.we_n <= 1'b0;
                     cnt_r <= 20'(WC_CYC);
                     state_r <= ST_WLOW;
                  end
                  if (is_cmd) begin
                     status_mode_r <= is_status;
                  end
                  if (is_data_in) begin
                     last_cache_r <= 1'b0;
                  end
                  if (is_cache) begin
                     last_cache_r <= 1'b1;
                  end
                  if (is_prog) begin
                     partial_r <= partial_r + 3'h1;
                     last_cache_r <= 1'b0;
                  end
                  if (is_reset) begin
                     reset_due_r <= 1'b0;
                     // Forget the cached end, or the next ready status
                     // would demand a reset all over again
                     last_cache_r <= 1'b0;
                     partial_r <= '0;
                  end
               end
            end
            ST_WLOW: begin
               cnt_r <= cnt_r - 20'h1;
               if (cnt_r == 20'h1) begin
                  pins_r.we_n <= 1'b1;
                  cnt_r <= is_cmd_done(pins_r.cle, io_r, RST_WAIT);
                  state_r <= ST_WB;
               end
            end
            ST_WB: begin
               // Keeps the bus quiet through the busy onset window
               cnt_r <= cnt_r - 20'h1;
               if (cnt_r <= 20'h1) begin
                  pins_r.cle <= 1'b0;
                  pins_r.ale <= 1'b0;
                  oe_r <= 1'b0;
                  state_r <= ST_IDLE;
               end
            end
            ST_RLOW: begin
               cnt_r <= cnt_r - 20'h1;
               if (cnt_r == 20'h1) begin
                  rdata_r <= io_i;
                  rvalid_r <= 1'b1;
                  pins_r.read_strobe_n <= 1'b1;
                  if (status_mode_r && last_cache_r &&
                        io_i[STATUS_RDY_BIT]) begin
                     reset_due_r <= 1'b1;
                  end
                  cnt_r <= 20'(RHW_CYC);
                  state_r <= ST_RHIGH;
               end
            end
            default: begin
               // Long strobe-high gap lets the device release the bus
               cnt_r <= cnt_r - 20'h1;
               if (cnt_r == 20'h1) begin
                  state_r <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // Post-write wait: reset waits its full recovery, others tWB/tWHR
   function automatic logic [19:0] is_cmd_done(input logic cle,
         input logic [7:0] d, input int rw);
      int w;
      w = WB_CYC > WHR_CYC ? WB_CYC : WHR_CYC;
      if (cle && d == CMD_RESET) begin
         w = rw;
      end
      return 20'(w);
   endfunction : is_cmd_done

   property p_no_contention;
      @(posedge clock_i) disable iff (!rstn_i)
         !pins_r.read_strobe_n |-> !oe_r;
   endproperty
   a_no_contention: assert property (p_no_contention)
      else $error("Host drives bus during read");

   property p_col_limit;
      @(posedge clock_i) disable iff (!rstn_i)
         req_valid_i && req_i.op == NHC_OP_WDATA && req_i.col > COL_LAST
         && idle |=> refused_o && state_r == ST_IDLE;
   endproperty
   a_col_limit: assert property (p_col_limit)
      else $error("Column past page end was not refused");

   property p_busy_wait;
      @(posedge clock_i) disable iff (!rstn_i)
         idle && req_valid_i && !rb_sync && req_i.op == NHC_OP_WDATA
         |=> state_r == ST_IDLE;
   endproperty
   a_busy_wait: assert property (p_busy_wait)
      else $error("Data accepted while busy");

   property p_partial;
      @(posedge clock_i) disable iff (!rstn_i)
         partial_r <= 3'(PARTIAL_MAX);
   endproperty
   a_partial: assert property (p_partial)
      else $error("Partial program count exceeded");

   property p_reset_gate;
      @(posedge clock_i) disable iff (!rstn_i)
         reset_due_r && idle && req_valid_i && req_i.op == NHC_OP_ADDR
         |=> refused_o;
   endproperty
   a_reset_gate: assert property (p_reset_gate)
      else $error("Operation allowed before required reset");

   property p_strobe_width;
      @(posedge clock_i) disable iff (!rstn_i)
         $fell(pins_r.we_n) |-> !pins_r.we_n [*3];
   endproperty
   a_strobe_width: assert property (p_strobe_width)
      else $error("Write strobe too short");

   property p_read_cycle;
      @(posedge clock_i) disable iff (!rstn_i)
         $fell(pins_r.read_strobe_n) |-> ##[1:3] rvalid_r;
   endproperty
   a_read_cycle: assert property (p_read_cycle)
      else $error("Read cycle did not deliver data");

   property p_status_bit;
      @(posedge clock_i) disable iff (!rstn_i)
         state_r == ST_RLOW && cnt_r == 20'h1 && status_mode_r &&
         last_cache_r && io_i[STATUS_RDY_BIT] |=> reset_due_r;
   endproperty
   a_status_bit: assert property (p_status_bit)
      else $error("Ready status did not demand reset");

   c_write: cover property (@(posedge clock_i) $rose(pins_r.we_n));
   c_read: cover property (@(posedge clock_i) rvalid_r);
   c_refuse: cover property (@(posedge clock_i) refused_r);
   c_need_reset: cover property (@(posedge clock_i) $rose(reset_due_r));
endmodule : nhc_host

/* nhc_pkg.sv */
package nhc_pkg;
   // Command codes
   localparam logic [7:0] CMD_SERIAL_IN = 8'h80;
   localparam logic [7:0] CMD_PLANE2_IN = 8'h81;
   localparam logic [7:0] CMD_PROG = 8'h10;
   localparam logic [7:0] CMD_PROG_PLANE = 8'h11;
   localparam logic [7:0] CMD_PROG_CACHE = 8'h15;
   localparam logic [7:0] CMD_READ_END = 8'h3f;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_RESET = 8'hff;
   localparam int STATUS_RDY_BIT = 6;
   localparam logic [12:0] COL_LAST = 13'h10ff;
   localparam int PARTIAL_MAX = 4;
   // Timing, in ns (reset recovery in us), and derived cycles at 100 MHz
   localparam int CLK_NS = 10;
   localparam int T_WC_NS = 25;
   localparam int T_WB_NS = 100;
   localparam int T_WHR_NS = 60;
   localparam int T_REA_NS = 20;
   localparam int T_RHW_NS = 30;
   localparam int WC_CYC = (T_WC_NS + CLK_NS - 1) / CLK_NS;
   localparam int WB_CYC = (T_WB_NS + CLK_NS - 1) / CLK_NS;
   localparam int WHR_CYC = (T_WHR_NS + CLK_NS - 1) / CLK_NS;
   localparam int REA_CYC = (T_REA_NS + CLK_NS - 1) / CLK_NS;
   localparam int RHW_CYC = (T_RHW_NS + CLK_NS - 1) / CLK_NS;
   localparam int RST_US = 500;
   localparam int RST_CYC = RST_US * 1000 / CLK_NS;

   typedef enum logic [1:0] {
      NHC_OP_CMD,
      NHC_OP_ADDR,
      NHC_OP_WDATA,
      NHC_OP_RDATA
   } nhc_op_type;

   typedef struct packed {
      nhc_op_type op;
      logic [7:0] data;
      logic [12:0] col;
   } nhc_req_type;

   typedef struct packed {
      logic cle;
      logic ale;
      logic ce_n;
      logic we_n;
      logic read_strobe_n;
   } nhc_pins_type;
endpackage : nhc_pkg

/* nhc_sync.sv */
module nhc_sync (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rstn_i,
   // Asynchronous level
   input wire logic async_i,
   output logic sync_o
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         s1_r <= 1'b1;
         s2_r <= 1'b1;
         s3_r <= 1'b1;
         sync_o <= 1'b1;
      end else begin
         s1_r <= async_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         // Change counts once two late stages agree
         if (s2_r == s3_r) begin
            sync_o <= s3_r;
         end
      end
   end
endmodule : nhc_sync

/* nhc_flash_model.sv */
module nhc_flash_model (
   // Clock for busy timing
   input wire logic clock_i,
   // Host pins
   input wire nhc_pkg::nhc_pins_type pins_i,
   input wire logic [7:0] io_i,
   // Device answers
   output logic ready_busy_n_o,
   output logic [7:0] io_o
);
   timeunit 1ns;
   timeprecision 100ps;
   import nhc_pkg::*;
   logic [7:0] last_cmd_r;
   logic we_q_r;
   int busy_left;
   initial begin
      io_o = 8'h00;
      last_cmd_r = 8'h00;
      we_q_r = 1'b1;
      busy_left = 0;
   end
   // Busy lengths differ per command so the host sees prompt and slow ends
   always @(posedge clock_i) begin
      we_q_r <= pins_i.we_n;
      if (busy_left > 0) busy_left <= busy_left - 1;
      if (!we_q_r && pins_i.we_n && pins_i.cle && !pins_i.ce_n) begin
         last_cmd_r <= io_i;
         case (io_i)
            CMD_PROG: busy_left <= 60;
            CMD_PROG_CACHE: busy_left <= 80;
            CMD_PROG_PLANE: busy_left <= 20;
            8'h3a: busy_left <= 30;
            CMD_RESET: busy_left <= 10;
            default: ;
         endcase
      end
   end
   assign ready_busy_n_o = (busy_left == 0);
   always @(negedge pins_i.read_strobe_n) begin
      // Just inside the access time, so data never lands on a clock edge
      #(T_REA_NS - 1);
      io_o = {1'b0, ready_busy_n_o, 6'h00};
   end
   // Released lines show the inverse so a late sample cannot pass by luck
   always @(posedge pins_i.read_strobe_n) begin
      #25;
      io_o = ~io_o;
   end
endmodule : nhc_flash_model

/* tb.sv */
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import nhc_pkg::*;
   logic clock_i, rstn_i, req_valid_i, rb_n;
   nhc_req_type req_i;
   nhc_pins_type pins;
   logic req_ready_o, rdata_valid_o, refused_o, need_reset_o, io_oe_o;
   logic [7:0] rdata_o, io_o, io_dev;
   int err_count = 0, comparisons = 0, cyc = 0;
   logic [7:0] rd;
   nhc_host #(.RST_WAIT(20)) nhc_host_i (.clock_i(clock_i), .rstn_i(rstn_i),
      .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
      .rdata_valid_o(rdata_valid_o), .rdata_o(rdata_o),
      .refused_o(refused_o), .need_reset_o(need_reset_o), .pins_o(pins),
      .ready_busy_n_i(rb_n), .io_i(io_dev), .io_o(io_o), .io_oe_o(io_oe_o));
   nhc_flash_model nhc_flash_model_i (.clock_i(clock_i), .pins_i(pins),
      .io_i(io_o), .ready_busy_n_o(rb_n), .io_o(io_dev));
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   function automatic logic [7:0] exp_status(input logic rdy);
      return {1'b0, rdy, 6'h00};
   endfunction : exp_status
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic test_done;
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : test_done
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 60000) begin
         err_count++;
         test_done();
      end
   end
   // One request, held until the edge that takes it, refusal seen in 2 cycles
   task automatic req(input nhc_op_type op, input logic [7:0] d,
         input logic [12:0] c, input logic xr);
      logic seen;
      int n;
      seen = 1'b0;
      n = 0;
      while (req_ready_o !== 1'b1 && n < 2000) begin
         @(posedge clock_i); #1; n++;
      end
      req_valid_i = 1'b1;
      req_i = '{op: op, data: d, col: c};
      @(posedge clock_i); #1;
      req_valid_i = 1'b0;
      seen = (refused_o === 1'b1);
      @(posedge clock_i); #1;
      seen = seen | (refused_o === 1'b1);
      chk("refused", {7'h0, xr}, {7'h0, seen});
      n = 0;
      if (op == NHC_OP_RDATA && !xr) begin
         while (rdata_valid_o !== 1'b1 && n < 20) begin
            @(posedge clock_i); #1; n++;
         end
         chk("oe_in_read", 8'h00, {7'h0, io_oe_o});
         rd = rdata_o;
      end
   endtask : req
   task automatic poll;
      int n;
      n = 0;
      rd = 8'h00;
      while (rd[STATUS_RDY_BIT] !== 1'b1 && n < 200) begin
         req(NHC_OP_CMD, CMD_STATUS, 13'h0, 1'b0);
         req(NHC_OP_RDATA, 8'h00, 13'h0, 1'b0);
         n++;
      end
      chk("status_ready", exp_status(1'b1), rd);
   endtask : poll
   task automatic load(input logic [7:0] c);
      req(NHC_OP_CMD, c, 13'h0, 1'b0);
      req(NHC_OP_ADDR, 8'($urandom), 13'h0, 1'b0);
      repeat (3) req(NHC_OP_WDATA, 8'($urandom),
         13'($urandom_range(0, 4351)), 1'b0);
   endtask : load
   initial begin
      rstn_i = 1'b0;
      req_valid_i = 1'b0;
      req_i = '0;
      void'($urandom(68760));
      repeat (4) @(posedge clock_i);
      #1 rstn_i = 1'b1;
      load(CMD_SERIAL_IN);
      req(NHC_OP_WDATA, 8'h3c, COL_LAST, 1'b0);
      req(NHC_OP_WDATA, 8'h3c, COL_LAST + 13'h1, 1'b1);
      req(NHC_OP_CMD, CMD_PROG, 13'h0, 1'b0);
      req(NHC_OP_CMD, CMD_SERIAL_IN, 13'h0, 1'b1);
      req(NHC_OP_WDATA, 8'h5a, 13'h0, 1'b1);
      req(NHC_OP_CMD, CMD_STATUS, 13'h0, 1'b0);
      req(NHC_OP_RDATA, 8'h00, 13'h0, 1'b0);
      chk("status_busy", exp_status(1'b0), rd);
      poll();
      req(NHC_OP_CMD, CMD_READ_END, 13'h0, 1'b0);
      poll();
      load(CMD_SERIAL_IN);
      req(NHC_OP_CMD, CMD_PROG_CACHE, 13'h0, 1'b0);
      poll();
      chk("need_reset", 8'h01, {7'h0, need_reset_o});
      req(NHC_OP_CMD, CMD_SERIAL_IN, 13'h0, 1'b1);
      req(NHC_OP_ADDR, 8'($urandom), 13'h0, 1'b1);
      req(NHC_OP_CMD, CMD_RESET, 13'h0, 1'b0);
      poll();
      chk("need_reset_clr", 8'h00, {7'h0, need_reset_o});
      for (int i = 0; i < 5; i++) begin
         load(i[0] ? CMD_PLANE2_IN : CMD_SERIAL_IN);
         req(NHC_OP_CMD, CMD_PROG, 13'h0, i == PARTIAL_MAX);
         poll();
      end
      test_done();
   end
endmodule : tb
